// file: testbench/pmsc_proc_model.sv
// Processor-side model: low-power request pin and power button
`timescale 1ns/1ps
module pmsc_proc_model (
    input wire logic want_low_power,
    input wire logic want_awake,
    input wire logic active_low,
    output logic low_power_pin,
    output logic power_button_in
);
    ////////////////////////////////////////////////////////////
    // Pin flipped when the board wires it active low
    assign low_power_pin = want_low_power ^ active_low;
    // Button held while awake; letting go allows sleep
    assign power_button_in = want_awake;
endmodule

// file: testbench/pmsc_top_asserts.sv
// Concurrent checks on the ports of the power-mode state control top
`timescale 1ns/1ps
module pmsc_top_asserts (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic thermal_shutdown,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic host_ack,
    input wire logic host_nack,
    input wire logic processor_reset_n,
    input wire logic fault_interrupt_n,
    input wire logic core_digital_supply,
    input wire logic backup_domain_supply,
    input wire logic regulators_on,
    input wire logic [2:0] power_state
);
    ////////////////////////////////////////////////////////////
    // One domain; outputs are registered, so levels are judged a cycle into a state
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    a_start_resting: assert property ($past(rst_n, 2) == 1'b0 |-> power_state <= 3'h1)
        else $error("active state after reset");
    a_off_exit: assert property (power_state == 3'h1 ##1 power_state != 3'h1 |->
        power_state inside {3'h0, 3'h2})
        else $error("bad exit from off");
    a_coin_exit: assert property ($past(power_state) == 3'h0 && power_state != 3'h0 |->
        power_state == 3'h1)
        else $error("bad exit from coin");
    a_standby_entry: assert property (power_state == 3'h4 |->
        $past(power_state) inside {3'h2, 3'h4})
        else $error("standby not from on");
    a_thermal_off: assert property (thermal_shutdown && power_state inside {3'h2, 3'h3, 3'h4} |->
        ##[1:4] power_state == 3'h1)
        else $error("thermal not to off");
    a_off_outputs: assert property (power_state == 3'h1 && $past(power_state) == 3'h1 |->
        !processor_reset_n && !regulators_on && core_digital_supply && backup_domain_supply)
        else $error("off outputs wrong");
    a_on_reset_high: assert property (power_state == 3'h2 && $past(power_state) == 3'h2 |->
        processor_reset_n)
        else $error("reset low in on");
    a_coin_reset_low: assert property (power_state == 3'h0 && $past(power_state) == 3'h0 |->
        !processor_reset_n)
        else $error("reset high in coin");
    a_irq_quiet: assert property (power_state <= 3'h1 && $past(power_state) <= 3'h1 |->
        fault_interrupt_n)
        else $error("interrupt in off or coin");
    a_coin_refuse: assert property ((host_wr || host_rd) && power_state == 3'h0 |=>
        host_nack && !host_ack)
        else $error("access taken in coin");
endmodule
bind pmsc_top pmsc_top_asserts u_asserts (
    .clk(clk), .rst_n(rst_n), .thermal_shutdown(thermal_shutdown), .host_wr(host_wr), .host_rd(host_rd),
    .host_ack(host_ack), .host_nack(host_nack), .processor_reset_n(processor_reset_n),
    .fault_interrupt_n(fault_interrupt_n), .core_digital_supply(core_digital_supply),
    .backup_domain_supply(backup_domain_supply), .regulators_on(regulators_on), .power_state(power_state)
);

// file: testbench/pmsc_top_bench.sv
// Self-checking bench for the power-mode state control block
`timescale 1ns/1ps
module pmsc_top_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic bcr_n = 1'b1, uv_ok = 1'b1, ton = 1'b0, toff = 1'b0, tsd = 1'b0, flt = 1'b0, fmask = 1'b0;
    logic wr = 1'b0, rd = 1'b0, want_lp = 1'b0, awake = 1'b1, act_low = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, rv;
    logic ack, nack, prst_n, irq_n, core_s, bk_s, regs_on, button, lp_pin;
    logic [1:0] rs;
    logic [2:0] state;
    logic [3:0] ren, rpm;
    logic [27:0] rsp;
    int n_errors = 0;
    int check_count = 0;
    int n;
    always #10 clk = ~clk;
    pmsc_top #(.NUM_REG(4)) u_dut (
        .clk(clk), .rst_n(rst_n), .backup_cell_reset_n(bcr_n), .supply_above_uv(uv_ok), .turn_on_event(ton),
        .turn_off_event(toff), .thermal_shutdown(tsd), .power_button_in(button), .low_power_pin(lp_pin),
        .fault_event(flt), .fault_mask(fmask), .host_wr(wr), .host_rd(rd), .host_addr(addr), .host_wdata(wdata),
        .host_rdata(rdata), .host_ack(ack), .host_nack(nack), .processor_reset_n(prst_n), .fault_interrupt_n(irq_n),
        .core_digital_supply(core_s), .backup_domain_supply(bk_s), .regulators_on(regs_on), .power_state(state),
        .regulator_enable(ren), .regulator_pulse_mode(rpm), .regulator_setpoint(rsp)
    );
    pmsc_proc_model u_proc (.want_low_power(want_lp), .want_awake(awake), .active_low(act_low),
        .low_power_pin(lp_pin), .power_button_in(button));
    ////////////////////////////////////////////////////////////
    // Shared helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Fixed latency: answer lands at the taking edge, so strobe drops there
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= w;
        rd <= ~w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
        rv = rdata;
        rs = {ack, nack};
    endtask
    task automatic wait_state(input logic [2:0] s);
        n = 0;
        while (state !== s && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(state, s);
        if (state !== s) test_done();
    endtask
    task automatic pulse(input logic off);
        @(posedge clk);
        ton <= ~off;
        toff <= off;
        repeat (3) @(posedge clk);
        ton <= 1'b0;
        toff <= 1'b0;
        #1;
    endtask
    // Supply held steady before release, since it is sampled late
    task automatic do_reset(input logic sup);
        @(posedge clk) rst_n <= 1'b0;
        uv_ok <= sup;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_off_on();
        do_reset(1'b1);
        check(state, pmsc_pkg::PMSC_OFF);
        check({prst_n, core_s, bk_s, regs_on}, 4'h6);
        bus(1'b0, 8'h1B, 8'h00);
        check({rs, rv}, {2'b10, 8'h10});
        @(posedge clk) want_lp <= 1'b1;
        flt <= 1'b1;
        repeat (8) @(posedge clk);
        #1;
        check({state, irq_n}, {pmsc_pkg::PMSC_OFF, 1'b1});
        @(posedge clk) want_lp <= 1'b0;
        repeat (4) @(posedge clk);
        pulse(1'b0);
        wait_state(pmsc_pkg::PMSC_ON);
        repeat (2) @(posedge clk);
        #1;
        check({prst_n, irq_n}, 2'b10);
        @(posedge clk) flt <= 1'b0;
        $display("done off_on");
    endtask
    task automatic t_sleep();
        bus(1'b1, 8'h2F, 8'h05);
        bus(1'b1, 8'h20, 8'hFF);
        bus(1'b1, 8'h22, 8'hD5);
        @(posedge clk) awake <= 1'b0;
        wait_state(pmsc_pkg::PMSC_SLEEP);
        @(posedge clk) flt <= 1'b1;
        fmask <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check({ren, rpm, irq_n}, {8'h55, 1'b1});
        check({rsp[20:14], rsp[6:0]}, {7'h55, 7'h3F});
        @(posedge clk) fmask <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        check(irq_n, 1'b0);
        @(posedge clk) awake <= 1'b1;
        flt <= 1'b0;
        wait_state(pmsc_pkg::PMSC_ON);
        $display("done sleep");
    endtask
    // Polarity changes only in off, where the pin is ignored, so no false request
    task automatic t_standby();
        for (int p = 0; p < 2; p++) begin
            for (int d = 0; d < 4; d++) begin
                pulse(1'b1);
                wait_state(pmsc_pkg::PMSC_OFF);
                bus(1'b1, 8'h1B, {1'b0, p[0], d[1:0], 4'h0});
                @(posedge clk) act_low <= p[0];
                pulse(1'b0);
                wait_state(pmsc_pkg::PMSC_ON);
                repeat (6) @(posedge clk);
                want_lp <= 1'b1;
                n = 0;
                while (state !== pmsc_pkg::PMSC_STANDBY && n < 20) begin
                    @(posedge clk);
                    #1;
                    n++;
                end
                check(n, d + 5);
                @(posedge clk) want_lp <= 1'b0;
                wait_state(pmsc_pkg::PMSC_ON);
            end
        end
        $display("done standby");
    endtask
    task automatic t_thermal();
        @(posedge clk) tsd <= 1'b1;
        wait_state(pmsc_pkg::PMSC_OFF);
        repeat (2) @(posedge clk);
        #1;
        check({prst_n, regs_on}, 2'b00);
        @(posedge clk) tsd <= 1'b0;
        bus(1'b1, 8'h1B, 8'h70);
        @(posedge clk) bcr_n <= 1'b0;
        repeat (2) @(posedge clk);
        bcr_n <= 1'b1;
        bus(1'b0, 8'h1B, 8'h00);
        check(rv, 8'h10);
        $display("done thermal");
    endtask
    task automatic t_coin();
        do_reset(1'b0);
        check(state, pmsc_pkg::PMSC_COIN);
        bus(1'b1, 8'h1B, 8'h00);
        check(rs, 2'b01);
        pulse(1'b0);
        repeat (6) @(posedge clk);
        #1;
        check({state, prst_n}, {pmsc_pkg::PMSC_COIN, 1'b0});
        @(posedge clk) uv_ok <= 1'b1;
        wait_state(pmsc_pkg::PMSC_OFF);
        bus(1'b0, 8'h1B, 8'h00);
        check({rs, rv}, {2'b10, 8'h10});
        $display("done coin");
    endtask
    initial begin
        t_off_on();
        t_sleep();
        t_standby();
        t_thermal();
        t_coin();
        test_done();
    end
    initial begin
        #500000;
        n_errors++;
        test_done();
    end
endmodule

// file: verilog/pmsc_lp_if.sv
// Interface between the state machine and the low-power request qualifier
`timescale 1ns/1ps
interface pmsc_lp_if;
    logic pin_level;
    logic polarity_invert;
    logic [1:0] entry_delay;
    logic enable;
    logic request;
    logic pin_asserted;
    modport ctrl (output pin_level, output polarity_invert, output entry_delay, output enable,
                  input request, input pin_asserted);
    modport qual (input pin_level, input polarity_invert, input entry_delay, input enable,
                  output request, output pin_asserted);
endinterface

// file: verilog/pmsc_lp_qual.sv
// Low-power request qualifier: synchroniser, polarity and entry delay
`timescale 1ns/1ps
module pmsc_lp_qual (
    input wire logic clk,
    input wire logic rst_n,
    pmsc_lp_if.qual lp
);
    typedef struct packed {
        logic [pmsc_pkg::PMSC_SYNC_STAGES-1:0] sync;
        logic [1:0] count;
        logic request;
    } pmsc_qual_t;

    pmsc_qual_t q;
    pmsc_qual_t next_q;
    logic level;

    ////////////////////////////////////////////////////////////////
    // Three-stage synchroniser; only the last stage is decoded
    always_comb begin
        next_q = q;
        next_q.sync = {q.sync[pmsc_pkg::PMSC_SYNC_STAGES-2:0], lp.pin_level};
        level = q.sync[pmsc_pkg::PMSC_SYNC_STAGES-1] ^ lp.polarity_invert;
        if (!lp.enable || !level) begin
            // Deassertion or leaving ON drops the request at once
            next_q.request = 1'b0;
            next_q.count = 2'h0;
        end else if (!q.request) begin
            // Hold off entry for the programmed number of periods
            if (q.count >= lp.entry_delay) begin
                next_q.request = 1'b1;
            end else begin
                next_q.count = q.count + 2'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign lp.request = q.request;
    // Decoded pin level for the Standby exit, valid whatever the enable
    assign lp.pin_asserted = q.sync[pmsc_pkg::PMSC_SYNC_STAGES-1] ^ lp.polarity_invert;
endmodule

// file: verilog/pmsc_pkg.sv
// Package of constants and types for the power-mode state control block
package pmsc_pkg;
    localparam logic [7:0] PMSC_ADDR_POWER_CONTROL = 8'h1B;
    localparam int PMSC_POL_INV_BIT = 6;
    localparam int PMSC_DLY_HI = 5;
    localparam int PMSC_DLY_LO = 4;
    localparam logic [7:0] PMSC_POWER_CONTROL_RESET = 8'h10;
    localparam logic [1:0] PMSC_DLY_NONE = 2'h0;
    localparam int PMSC_SYNC_STAGES = 3;
    localparam int PMSC_NUM_REG = 4;
    localparam int PMSC_SP_WIDTH = 7;
    localparam int PMSC_SP_GROUP_ONE_WIDTH = 6;
    localparam logic [7:0] PMSC_ADDR_SP_BASE = 8'h20;
    localparam logic [7:0] PMSC_ADDR_KEEP_ON = 8'h2F;
    localparam logic [7:0] PMSC_ADDR_ON_SP_BASE = 8'h30;
    localparam logic [7:0] PMSC_ADDR_STATE = 8'h3F;
    typedef enum logic [2:0] {
        PMSC_COIN,
        PMSC_OFF,
        PMSC_ON,
        PMSC_SLEEP,
        PMSC_STANDBY
    } pmsc_state_t;
endpackage

// file: verilog/pmsc_top.sv
// Power-mode state control: state machine, control register and outputs
`timescale 1ns/1ps
//
// Contract
// - Five states with defined entry and exit
// - Power-up only above rising undervoltage level
// - Reject host-bus access in Coin Cell
// - Interrupt only in Sleep, Standby, ON
// - Turn-on enters ON, reset released
// - Turn-off or thermal shutdown enters OFF
// - OFF: core supplies only, reset low
// - Standby follows qualified low-power request
// - Request is pin XOR polarity bit
// - Low-power pin ignored outside ON (Standby exits to ON on its deassertion)
// - Low-power settings copied from ON settings
// - Entry delay field selects 0..3 periods
// - Pin synchronised, three extra cycles
// - Sleep when button released, keep-on set
// - Sleep uses sleep set points until turn-on
// - Sleep: keep-on 0 off, 1 pulse mode
// - Interrupts keep working during Sleep
// - Coin Cell ignores turn-on, reset low
// - Coin Cell to OFF when supply rises
// - Depleted cell restores all defaults (ON set points are kept)
module pmsc_top #(
    parameter int NUM_REG = pmsc_pkg::PMSC_NUM_REG
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic backup_cell_reset_n,
    input wire logic supply_above_uv,
    input wire logic turn_on_event,
    input wire logic turn_off_event,
    input wire logic thermal_shutdown,
    input wire logic power_button_in,
    input wire logic low_power_pin,
    input wire logic fault_event,
    input wire logic fault_mask,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [7:0] host_addr,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    output logic host_ack,
    output logic host_nack,
    output logic processor_reset_n,
    output logic fault_interrupt_n,
    output logic core_digital_supply,
    output logic backup_domain_supply,
    output logic regulators_on,
    output logic [2:0] power_state,
    output logic [NUM_REG-1:0] regulator_enable,
    output logic [NUM_REG-1:0] regulator_pulse_mode,
    output logic [NUM_REG*pmsc_pkg::PMSC_SP_WIDTH-1:0] regulator_setpoint
);
    localparam int SPW = pmsc_pkg::PMSC_SP_WIDTH;

    typedef struct packed {
        logic [1:0] sync_uv;
        logic [2:0] sync_on;
        logic [2:0] sync_off;
        logic [1:0] sync_th;
        logic [1:0] sync_btn;
        logic [1:0] sync_flt;
        logic [1:0] sync_bcr;
        logic [1:0] settle;
        pmsc_pkg::pmsc_state_t state;
        logic started;
        logic [7:0] power_control;
        logic [NUM_REG-1:0] keep_on;
        logic [NUM_REG*SPW-1:0] on_sp;
        logic [NUM_REG*SPW-1:0] sleep_sp;
        logic [NUM_REG*SPW-1:0] active_sp;
        logic [7:0] rdata;
        logic ack;
        logic nack;
        logic rst_out_n;
        logic irq_n;
        logic core_sup;
        logic bkp_sup;
        logic reg_on;
        logic [NUM_REG-1:0] reg_en;
        logic [NUM_REG-1:0] reg_pfm;
    } pmsc_core_t;

    pmsc_core_t s;
    pmsc_core_t next_s;
    pmsc_lp_if lp ();
    logic uv_ok;
    logic on_edge;
    logic off_edge;
    logic thermal;
    logic button;
    logic fault;
    logic any_keep;
    logic cell_ok;
    logic [7:0] sel;

    ////////////////////////////////////////////////////////////////
    // Low-power request qualifier, enabled only in ON
    pmsc_lp_qual u_qual (
        .clk(clk),
        .rst_n(rst_n),
        .lp(lp.qual)
    );

    assign lp.pin_level = low_power_pin;
    assign lp.polarity_invert = s.power_control[pmsc_pkg::PMSC_POL_INV_BIT];
    assign lp.entry_delay = s.power_control[pmsc_pkg::PMSC_DLY_HI:pmsc_pkg::PMSC_DLY_LO];
    assign lp.enable = (s.state == pmsc_pkg::PMSC_ON);

    ////////////////////////////////////////////////////////////////
    // Pin inputs pass two flops; the third stage is only for edge detection
    assign uv_ok = s.sync_uv[1];
    assign thermal = s.sync_th[1];
    assign button = s.sync_btn[1];
    assign fault = s.sync_flt[1] & ~fault_mask;
    assign on_edge = s.sync_on[1] & ~s.sync_on[2];
    assign off_edge = s.sync_off[1] & ~s.sync_off[2];
    assign any_keep = |s.keep_on;
    assign cell_ok = s.sync_bcr[1];

    ////////////////////////////////////////////////////////////////
    // Next-state logic for state machine, registers and outputs
    always_comb begin
        next_s = s;
        sel = 8'h00;
        // Shift every pin synchroniser by one stage
        next_s.sync_uv = {s.sync_uv[0], supply_above_uv};
        next_s.sync_on = {s.sync_on[1:0], turn_on_event};
        next_s.sync_off = {s.sync_off[1:0], turn_off_event};
        next_s.sync_th = {s.sync_th[0], thermal_shutdown};
        next_s.sync_btn = {s.sync_btn[0], power_button_in};
        next_s.sync_flt = {s.sync_flt[0], fault_event};
        next_s.sync_bcr = {s.sync_bcr[0], backup_cell_reset_n};
        next_s.settle = {s.settle[0], 1'b1};
        // Host answers are one-cycle pulses
        next_s.ack = 1'b0;
        next_s.nack = 1'b0;

        // Start state waits until the supply synchroniser holds a real sample,
        // otherwise its reset value would always pick Coin Cell first
        if (!s.started) begin
            if (s.settle[1]) begin
                next_s.started = 1'b1;
                if (uv_ok) begin
                    next_s.state = pmsc_pkg::PMSC_OFF;
                end else begin
                    next_s.state = pmsc_pkg::PMSC_COIN;
                end
                next_s.sleep_sp = s.on_sp;
            end
        end else begin
            unique case (s.state)
                pmsc_pkg::PMSC_COIN: begin
                    // Turn-on ignored here; only the supply moves us out
                    if (uv_ok) begin
                        next_s.state = pmsc_pkg::PMSC_OFF;
                    end
                end
                pmsc_pkg::PMSC_OFF: begin
                    if (!uv_ok) begin
                        next_s.state = pmsc_pkg::PMSC_COIN;
                    end else if (on_edge) begin
                        next_s.state = pmsc_pkg::PMSC_ON;
                    end
                end
                pmsc_pkg::PMSC_ON: begin
                    if (!uv_ok) begin
                        next_s.state = pmsc_pkg::PMSC_COIN;
                    end else if (thermal || off_edge) begin
                        next_s.state = pmsc_pkg::PMSC_OFF;
                    end else if (!button && any_keep) begin
                        next_s.state = pmsc_pkg::PMSC_SLEEP;
                    end else if (lp.request) begin
                        next_s.state = pmsc_pkg::PMSC_STANDBY;
                    end
                end
                pmsc_pkg::PMSC_STANDBY: begin
                    if (!uv_ok) begin
                        next_s.state = pmsc_pkg::PMSC_COIN;
                    end else if (thermal || off_edge) begin
                        next_s.state = pmsc_pkg::PMSC_OFF;
                    end else if (!button && any_keep) begin
                        next_s.state = pmsc_pkg::PMSC_SLEEP;
                    end else begin
                        // Qualifier is disabled outside ON, so exit on the synced, decoded pin
                        if (!lp.pin_asserted) begin
                            next_s.state = pmsc_pkg::PMSC_ON;
                        end
                    end
                end
                pmsc_pkg::PMSC_SLEEP: begin
                    if (!uv_ok) begin
                        next_s.state = pmsc_pkg::PMSC_COIN;
                    end else if (thermal || off_edge) begin
                        next_s.state = pmsc_pkg::PMSC_OFF;
                    end else if (button || on_edge) begin
                        // Button or a fresh turn-on wakes the device
                        next_s.state = pmsc_pkg::PMSC_ON;
                    end
                end
            endcase
        end

        // Depleted backup cell: power control, keep-on and sleep set points back to their defaults; ON set points kept
        if (!cell_ok) begin
            next_s.power_control = pmsc_pkg::PMSC_POWER_CONTROL_RESET;
            next_s.keep_on = '0;
            next_s.sleep_sp = s.on_sp;
        end

        // Host bus: refused outright in Coin Cell
        // and until the start state has been chosen
        if (host_wr || host_rd) begin
            if (s.state == pmsc_pkg::PMSC_COIN || !s.started) begin
                next_s.nack = 1'b1;
            end else begin
                next_s.ack = 1'b1;
                if (host_addr == pmsc_pkg::PMSC_ADDR_POWER_CONTROL) begin
                    sel = s.power_control;
                    if (host_wr) next_s.power_control = host_wdata;
                end else if (host_addr == pmsc_pkg::PMSC_ADDR_KEEP_ON) begin
                    sel = 8'(s.keep_on);
                    if (host_wr) next_s.keep_on = host_wdata[NUM_REG-1:0];
                end else if (host_addr == pmsc_pkg::PMSC_ADDR_STATE) begin
                    sel = 8'(s.state);
                end else begin
                    // Unmapped addresses read as zero and ignore writes
                    for (int i = 0; i < NUM_REG; i++) begin
                        if (host_addr == pmsc_pkg::PMSC_ADDR_SP_BASE + 8'(i)) begin
                            sel = 8'(s.sleep_sp[i*SPW +: SPW]);
                            if (host_wr) begin
                                next_s.sleep_sp[i*SPW +: SPW] = (i == 0) ?
                                    SPW'(host_wdata[pmsc_pkg::PMSC_SP_GROUP_ONE_WIDTH-1:0]) :
                                    host_wdata[SPW-1:0];
                            end
                        end
                        if (host_addr == pmsc_pkg::PMSC_ADDR_ON_SP_BASE + 8'(i)) begin
                            sel = 8'(s.on_sp[i*SPW +: SPW]);
                            if (host_wr) next_s.on_sp[i*SPW +: SPW] = host_wdata[SPW-1:0];
                        end
                    end
                end
                next_s.rdata = sel;
            end
        end

        // Outputs by state
        next_s.rst_out_n = (next_s.state == pmsc_pkg::PMSC_ON) ||
                           (next_s.state == pmsc_pkg::PMSC_STANDBY) ||
                           (next_s.state == pmsc_pkg::PMSC_SLEEP);
        next_s.irq_n = !(fault && (next_s.state == pmsc_pkg::PMSC_ON ||
                                   next_s.state == pmsc_pkg::PMSC_STANDBY ||
                                   next_s.state == pmsc_pkg::PMSC_SLEEP));
        next_s.core_sup = 1'b1;
        next_s.bkp_sup = 1'b1;
        next_s.reg_on = (next_s.state == pmsc_pkg::PMSC_ON) || (next_s.state == pmsc_pkg::PMSC_STANDBY) ||
                        (next_s.state == pmsc_pkg::PMSC_SLEEP);
        if (next_s.state == pmsc_pkg::PMSC_SLEEP) begin
            next_s.reg_en = s.keep_on;
            next_s.reg_pfm = s.keep_on;
            if (s.state != pmsc_pkg::PMSC_SLEEP) next_s.active_sp = s.sleep_sp;
        end else if (next_s.reg_on) begin
            next_s.reg_en = '1;
            next_s.reg_pfm = '0;
            next_s.active_sp = s.on_sp;
        end else begin
            next_s.reg_en = '0;
            next_s.reg_pfm = '0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // State register; reset leaves the interrupt pin idle high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.state <= pmsc_pkg::PMSC_COIN;
            s.power_control <= pmsc_pkg::PMSC_POWER_CONTROL_RESET;
            s.irq_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // Every output comes straight from its flop
    assign host_rdata = s.rdata;
    assign host_ack = s.ack;
    assign host_nack = s.nack;
    assign processor_reset_n = s.rst_out_n;
    assign fault_interrupt_n = s.irq_n;
    assign core_digital_supply = s.core_sup;
    assign backup_domain_supply = s.bkp_sup;
    assign regulators_on = s.reg_on;
    assign power_state = 3'(s.state);
    assign regulator_enable = s.reg_en;
    assign regulator_pulse_mode = s.reg_pfm;
    assign regulator_setpoint = s.active_sp;
endmodule
